// ==== hdl/scs_regs.vh ====
// Purpose: constants for the sensor command port and conversion sequencer
// Assumes: included by scs_top.v only
// Notes:   command codes double as register addresses
`ifndef SCS_REGS_VH
`define SCS_REGS_VH
// ----------------------------------------
// command codes and register indices
// ----------------------------------------
`define SCS_CMD_ID     8'h01
`define SCS_CMD_STAT   8'h02
`define SCS_CMD_IDAT   8'h03
`define SCS_CMD_QDAT   8'h04
`define SCS_CMD_ADCST  8'h05
`define SCS_CMD_QUICK  8'h90
`define SCS_CFG_PAGE   3'h1
`define SCS_RW_BIT     4
`define SCS_IDX_EDIV   4'h0
`define SCS_IDX_CTL    4'ha
`define SCS_IDX_BLANK  4'hb
`define SCS_IDX_PM     4'hc
`define SCS_CFG_N      13
// ----------------------------------------
// reset values and fields
// ----------------------------------------
`define SCS_BLANK_RST  16'h003f
`define SCS_PM_RST     16'h00ff
`define SCS_MODE_OFF   2'h0
`define SCS_MODE_SGL   2'h1
`define SCS_CTL_MODE   1:0
`define SCS_CTL_NSEL   5:4
`define SCS_BLANK_THR  5:0
`define SCS_EDIV_FLD   2:0
`define SCS_DONE_BIT   0
// ----------------------------------------
// transfer lengths in bits
// ----------------------------------------
`define SCS_CMD_BITS   6'd8
`define SCS_WR_BITS    6'd24
`define SCS_MAX_BITS   6'h3f
`endif

// ==== hdl/scs_top.v ====
// Purpose: serial command port, blanked fault flags and I/Q conversion sequencer
// Assumes: SPI pins, sine tick and fault inputs are asynchronous to CLK
// Notes:   sclk is oversampled by CLK; sclk period must be at least 125 ns
// Function
// - each blanked fault has its own up/down counter
// - counters step once per transmitter sine period tick
// - blanked flags stay latched until status is read over the port
// - read code 0x2B returns the blanking count register
// - chip select is active high; transfers only while selected
// - capture on rising sclk, change output on falling sclk
// - sclk may idle low or high; no polarity setting needed
// - data output is released whenever chip select is low
// - all bytes are 8 bits, msb first both ways
// - write is command, high byte, low byte; unused bits zero
// - write echoes command, then returns zeros, and zeros after
// - register read is three bytes: echo, high byte, low byte
// - after the last read data bit, that bit repeats
// - code 0x90 is 40 bits: echo, I word, Q word
// - one paired read returns I and Q from the same sample set
// - after the paired read both data registers become zero
// - single mode settles then accumulates 4, 8 or 16 samples
// - channel select alternates converter between I and Q
// - finished single conversion loads results and sets done bit
// - no new single conversion until paired read or converter reset
// - continuous mode repeats and loads only complete matched pairs
// - control write with mode zero resets accumulators and converter
// - on the config page, command bit 4 set means write; write code is read code plus 0x10
// - 6-bit blanking threshold with reset value 0x003F
`timescale 1ns/1ps
`include "scs_regs.vh"
module scs_top #(
    parameter        SETTLE_CYC = 256,
    parameter [15:0] ID_CODE    = 16'h5a3c  // arbitrary value
) (
    input  wire        CLK,
    input  wire        RST,
    input  wire        SPI_CS,
    input  wire        SPI_SCLK,
    input  wire        SPI_MOSI,
    output reg         SPI_MISO,
    output wire        SPI_MISO_OE,
    input  wire        SINE_TICK,
    input  wire [7:0]  FAULT_BLANKED,
    input  wire [3:0]  FAULT_LIVE,
    input  wire [9:0]  ADC_DATA,
    input  wire        ADC_VALID,
    output reg         CHAN_SEL_MUX,
    output reg         CONV_DONE
);
// ----------------------------------------
// constants and functions
// ----------------------------------------
localparam NB = 8;
localparam S_IDLE = 2'h0;
localparam S_SETL = 2'h1;
localparam S_ACC  = 2'h2;
localparam S_DONE = 2'h3;
localparam [31:0] SET_LAST = SETTLE_CYC - 1;

// samples per channel chosen by the count field
function [4:0] nsamp;
    input [1:0] s;
    begin
        case (s)
            2'h0:    nsamp = 5'd4;
            2'h1:    nsamp = 5'd8;
            default: nsamp = 5'd16;
        endcase
    end
endfunction

// ----------------------------------------
// input synchronisers
// ----------------------------------------
reg [2:0]    sclk_q;
reg [1:0]    cs_q;
reg [1:0]    mosi_q;
reg [2:0]    sine_q;
reg [NB-1:0] fb1;
reg [NB-1:0] fb2;
reg [3:0]    fl1;
reg [3:0]    fl2;

// two flops per pin, third stage only for edge finding
always @(posedge CLK or posedge RST) begin
    if (RST) begin
        sclk_q <= 3'h0;
        cs_q   <= 2'h0;
        mosi_q <= 2'h0;
        sine_q <= 3'h0;
        fb1    <= {NB{1'b0}};
        fb2    <= {NB{1'b0}};
        fl1    <= 4'h0;
        fl2    <= 4'h0;
    end else begin
        sclk_q <= {sclk_q[1:0], SPI_SCLK};
        cs_q   <= {cs_q[0], SPI_CS};
        mosi_q <= {mosi_q[0], SPI_MOSI};
        sine_q <= {sine_q[1:0], SINE_TICK};
        fb1    <= FAULT_BLANKED;
        fb2    <= fb1;
        fl1    <= FAULT_LIVE;
        fl2    <= fl1;
    end
end

wire cs   = cs_q[1];
wire mosi = mosi_q[1];
// edges found from sampled levels, so either idle level works
wire rise = cs & sclk_q[1] & ~sclk_q[2];
wire fall = cs & ~sclk_q[1] & sclk_q[2];
wire tick = sine_q[1] & ~sine_q[2];

// ----------------------------------------
// serial port
// ----------------------------------------
reg  [5:0]  bitcnt;
reg  [7:0]  cmd;
reg  [15:0] rx;
reg  [31:0] sh;
reg         data_ph;
reg  [15:0] cfg [0:`SCS_CFG_N-1];
reg  [NB-1:0] flag;
reg  [13:0] i_data;
reg  [13:0] q_data;
reg         sts_clr;
reg         q_clr;
reg         ctl_wr;
reg  [15:0] rdval;
integer     k;
integer     m;

wire [7:0]  cmdn   = {rx[6:0], mosi};
wire [15:0] wdat   = {rx[14:0], mosi};
wire [3:0]  cidx   = cmdn[3:0];
wire        in_cfg = (cmdn[7:5] == `SCS_CFG_PAGE) && (cidx < `SCS_CFG_N);
wire        is_wr  = in_cfg && cmdn[`SCS_RW_BIT];
wire        w_cfg  = (cmd[7:5] == `SCS_CFG_PAGE) && cmd[`SCS_RW_BIT]
                     && (cmd[3:0] < `SCS_CFG_N);
wire [15:0] stat   = {cfg[`SCS_IDX_EDIV][`SCS_EDIV_FLD], fl2[3], fl2[2],
                      flag[7], fl2[1], flag[6], flag[5], 1'b0,
                      flag[4:1], fl2[0], flag[0]};
wire        quick  = (cmdn == `SCS_CMD_QUICK);

// read value chosen by the command just received
always @* begin
    rdval = 16'h0000;
    if (cmdn == `SCS_CMD_ID)
        rdval = ID_CODE;
    else if (cmdn == `SCS_CMD_STAT)
        rdval = stat;
    else if (cmdn == `SCS_CMD_IDAT)
        rdval = {2'h0, i_data};
    else if (cmdn == `SCS_CMD_QDAT)
        rdval = {2'h0, q_data};
    else if (cmdn == `SCS_CMD_ADCST)
        rdval = {15'h0000, CONV_DONE};
    else if (in_cfg && !cmdn[`SCS_RW_BIT])
        rdval = cfg[cidx];
end

// bit capture, command decode and output shifter
always @(posedge CLK or posedge RST) begin
    if (RST) begin
        bitcnt  <= 6'h00;
        cmd     <= 8'h00;
        rx      <= 16'h0000;
        sh      <= 32'h00000000;
        data_ph <= 1'b0;
        sts_clr <= 1'b0;
        q_clr   <= 1'b0;
    end else begin
        sts_clr <= 1'b0;
        q_clr   <= 1'b0;
        if (!cs) begin
            bitcnt  <= 6'h00;
            data_ph <= 1'b0;
        end else if (rise) begin
            rx <= wdat;
            if (bitcnt != `SCS_MAX_BITS)
                bitcnt <= bitcnt + 6'h01;
            if (bitcnt == `SCS_CMD_BITS - 6'h01) begin
                cmd     <= cmdn;
                data_ph <= 1'b1;
                sts_clr <= (cmdn == `SCS_CMD_STAT);
                q_clr   <= quick;
                if (quick)
                    sh <= {2'h0, i_data, 2'h0, q_data};
                else if (is_wr)
                    sh <= 32'h00000000;
                else
                    sh <= {rdval, {16{rdval[0]}}};
            end
        end else if (fall && data_ph) begin
            sh <= {sh[30:0], sh[0]};
        end
    end
end

// output bit: echo during command byte, then shifter on falling edge
always @(posedge CLK or posedge RST) begin
    if (RST)
        SPI_MISO <= 1'b0;
    else if (!cs)
        SPI_MISO <= 1'b0;
    else if (!data_ph)
        SPI_MISO <= mosi;
    else if (fall)
        SPI_MISO <= sh[31];
end

assign SPI_MISO_OE = cs;

// register writes commit on the last rising edge of the third byte
always @(posedge CLK or posedge RST) begin
    if (RST) begin
        for (k = 0; k < `SCS_CFG_N; k = k + 1)
            cfg[k] <= 16'h0000;
        cfg[`SCS_IDX_BLANK] <= `SCS_BLANK_RST;
        cfg[`SCS_IDX_PM]    <= `SCS_PM_RST;
        ctl_wr <= 1'b0;
    end else begin
        ctl_wr <= 1'b0;
        if (rise && w_cfg && bitcnt == `SCS_WR_BITS - 6'h01) begin
            cfg[cmd[3:0]] <= wdat;
            ctl_wr <= (cmd[3:0] == `SCS_IDX_CTL);
        end
    end
end

// ----------------------------------------
// fault blanking
// ----------------------------------------
reg  [5:0] bcnt [0:NB-1];
wire [5:0] thr = cfg[`SCS_IDX_BLANK][`SCS_BLANK_THR];

// one saturating up/down counter per blanked fault
always @(posedge CLK or posedge RST) begin
    if (RST) begin
        for (m = 0; m < NB; m = m + 1)
            bcnt[m] <= 6'h00;
        flag <= {NB{1'b0}};
    end else begin
        for (m = 0; m < NB; m = m + 1) begin
            if (tick && fb2[m] && bcnt[m] != `SCS_MAX_BITS)
                bcnt[m] <= bcnt[m] + 6'h01;
            else if (tick && !fb2[m] && bcnt[m] != 6'h00)
                bcnt[m] <= bcnt[m] - 6'h01;
            // set wins over the status-read clear
            if (fb2[m] && bcnt[m] >= thr)
                flag[m] <= 1'b1;
            else if (sts_clr)
                flag[m] <= 1'b0;
        end
    end
end

// ----------------------------------------
// conversion sequencer
// ----------------------------------------
reg  [1:0]  st;
reg  [15:0] tmr;
reg  [4:0]  pairs;
reg  [13:0] acc_i;
reg  [13:0] acc_q;
wire [1:0]  mode  = cfg[`SCS_IDX_CTL][`SCS_CTL_MODE];
wire [4:0]  nwant = nsamp(cfg[`SCS_IDX_CTL][`SCS_CTL_NSEL]);
wire [13:0] acc_qn = acc_q + {4'h0, ADC_DATA};
wire        off   = ctl_wr && mode == `SCS_MODE_OFF;

// settle, accumulate interleaved I/Q, hand over matched results
always @(posedge CLK or posedge RST) begin
    if (RST) begin
        st           <= S_IDLE;
        tmr          <= 16'h0000;
        pairs        <= 5'h00;
        acc_i        <= 14'h0000;
        acc_q        <= 14'h0000;
        CHAN_SEL_MUX <= 1'b0;
        CONV_DONE    <= 1'b0;
        i_data       <= 14'h0000;
        q_data       <= 14'h0000;
    end else begin
        if (q_clr) begin
            i_data <= 14'h0000;
            q_data <= 14'h0000;
        end
        if (off || q_clr)
            CONV_DONE <= 1'b0;
        if (off) begin
            st           <= S_IDLE;
            acc_i        <= 14'h0000;
            acc_q        <= 14'h0000;
            pairs        <= 5'h00;
            CHAN_SEL_MUX <= 1'b0;
        end else begin
            case (st)
                S_IDLE: begin
                    tmr <= 16'h0000;
                    if (ctl_wr && !CONV_DONE)
                        st <= S_SETL;
                end
                S_SETL: begin
                    tmr <= tmr + 16'h0001;
                    if ({16'h0000, tmr} >= SET_LAST) begin
                        st           <= S_ACC;
                        pairs        <= 5'h00;
                        acc_i        <= 14'h0000;
                        acc_q        <= 14'h0000;
                        CHAN_SEL_MUX <= 1'b0;
                    end
                end
                S_ACC: begin
                    if (ADC_VALID && !CHAN_SEL_MUX) begin
                        acc_i        <= acc_i + {4'h0, ADC_DATA};
                        CHAN_SEL_MUX <= 1'b1;
                    end else if (ADC_VALID) begin
                        CHAN_SEL_MUX <= 1'b0;
                        if (pairs + 5'h01 == nwant) begin
                            i_data <= acc_i;
                            q_data <= acc_qn;
                            pairs  <= 5'h00;
                            acc_i  <= 14'h0000;
                            acc_q  <= 14'h0000;
                            if (mode == `SCS_MODE_SGL) begin
                                CONV_DONE <= 1'b1;
                                st        <= S_DONE;
                            end
                        end else begin
                            acc_q <= acc_qn;
                            pairs <= pairs + 5'h01;
                        end
                    end
                end
                default: begin
                    if (q_clr)
                        st <= S_IDLE;
                end
            endcase
        end
    end
end
endmodule

// ==== sim/scs_props.sv ====
// Purpose: concurrent checks on the serial port and sequencer pins of scs_top
// Assumes: one clock domain, pins sampled by CLK as the hand-over describes
// Notes:   bound to scs_top at the foot of this file
`timescale 1ns/1ps
module scs_props #(
    parameter SETTLE_CYC = 256
) (
    input wire CLK,
    input wire RST,
    input wire SPI_CS,
    input wire SPI_SCLK,
    input wire SPI_MISO,
    input wire SPI_MISO_OE,
    input wire ADC_VALID,
    input wire CHAN_SEL_MUX,
    input wire CONV_DONE
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);
    // ----------------------------------------
    // serial port pins
    // ----------------------------------------
    a_oe_selected: assert property (SPI_CS [*4] |-> SPI_MISO_OE)
        else $error("output not enabled while selected");
    a_miso_released: assert property (!SPI_CS [*4] |-> !SPI_MISO_OE && !SPI_MISO)
        else $error("output driven while deselected");
    a_oe_rise_quiet: assert property ($rose(SPI_MISO_OE) |-> !SPI_MISO)
        else $error("output not low when enabled");
    a_miso_on_fall: assert property ($changed(SPI_MISO) && SPI_CS |-> !$past(SPI_SCLK, 3))
        else $error("output bit moved outside a falling clock");
    // ----------------------------------------
    // sequencer pins
    // ----------------------------------------
    a_chan_on_sample: assert property ($changed(CHAN_SEL_MUX) |-> $past(ADC_VALID))
        else $error("channel select moved without a sample");
    a_done_after_sample: assert property ($rose(CONV_DONE) |-> $past(ADC_VALID) && !CHAN_SEL_MUX)
        else $error("done rose without a final q sample");
    a_done_holds: assert property (!SPI_CS [*6] ##0 CONV_DONE |=> CONV_DONE)
        else $error("done dropped without a port command");
    a_done_clear_port: assert property ($fell(CONV_DONE) |-> $past(SPI_MISO_OE, 3))
        else $error("done cleared outside a transfer");
endmodule

bind scs_top scs_props #(
    .SETTLE_CYC (SETTLE_CYC)
) u_props (
    .CLK          (CLK),
    .RST          (RST),
    .SPI_CS       (SPI_CS),
    .SPI_SCLK     (SPI_SCLK),
    .SPI_MISO     (SPI_MISO),
    .SPI_MISO_OE  (SPI_MISO_OE),
    .ADC_VALID    (ADC_VALID),
    .CHAN_SEL_MUX (CHAN_SEL_MUX),
    .CONV_DONE    (CONV_DONE)
);

// ==== sim/scs_host.sv ====
// Purpose: behavioural serial host that frames transfers to the sensor port
// Assumes: serial clock period 125 ns, idle level chosen by cpol
// Notes:   released data line reads low through its weak pull-down
`timescale 1ns/1ps
module scs_host (
    input  wire clk,
    input  wire miso,
    input  wire miso_oe,
    output reg  cs,
    output reg  sclk,
    output reg  mosi
);
    reg  cpol;
    wire line = miso_oe ? miso : 1'b0; // pull-down when released
    // idle pins at time zero
    initial begin
        cs = 1'b0;
        sclk = 1'b0;
        mosi = 1'b0;
        cpol = 1'b0;
    end
    // one framed transfer: n bits of tx out msb first, n bits back in rx
    task xfer(input integer n, input [47:0] tx, output [47:0] rx);
        integer i;
        begin
            rx = 48'h0;
            // start off the clock grid so no pin moves on a sampling edge
            @(posedge clk);
            #1.25;
            // idle level settles before select, so no false edge at frame start
            sclk = cpol;
            #40;
            cs = 1'b1;
            #40;
            for (i = n - 1; i >= 0; i = i - 1) begin
                sclk = 1'b0;
                mosi = tx[i];
                #62.5;
                sclk = 1'b1;
                rx = {rx[46:0], line};
                #62.5;
            end
            sclk = cpol;
            #40;
            cs = 1'b0;
            mosi = 1'b0;
            #100;
        end
    endtask
endmodule

// ==== sim/testbench.sv ====
// Purpose: self-checking bench for the sensor port, blanking and sequencer
// Assumes: scs_host drives the serial pins, bench plays the converter
// Notes:   settle interval shortened to 8 cycles
`timescale 1ns/1ps
module testbench;
    localparam        SETTLE = 8;
    localparam [15:0] IDV    = 16'h5a3c; // arbitrary identification value
    localparam [31:0] POS    = {4'd10, 4'd8, 4'd7, 4'd5, 4'd4, 4'd3, 4'd2, 4'd0};
    reg         clk, rst, tick, avalid;
    reg  [7:0]  fblank;
    reg  [3:0]  flive;
    reg  [9:0]  adata;
    reg  [47:0] r;
    reg  [15:0] v, si, sq;
    wire        cs, sclk, mosi, miso, oe, chan, done;
    integer     n_errors, checks, k, j, nsel;
    scs_top #(.SETTLE_CYC(SETTLE), .ID_CODE(IDV)) uut (
        .CLK(clk), .RST(rst), .SPI_CS(cs), .SPI_SCLK(sclk), .SPI_MOSI(mosi),
        .SPI_MISO(miso), .SPI_MISO_OE(oe), .SINE_TICK(tick), .FAULT_BLANKED(fblank),
        .FAULT_LIVE(flive), .ADC_DATA(adata), .ADC_VALID(avalid),
        .CHAN_SEL_MUX(chan), .CONV_DONE(done));
    scs_host host (.clk(clk), .miso(miso), .miso_oe(oe), .cs(cs), .sclk(sclk), .mosi(mosi));
    // status bit of each blanked fault
    function [15:0] sbit(input integer b);
        sbit = 16'h1 << POS[b*4 +: 4];
    endfunction
    // compare and count
    task chk(input [47:0] got, input [47:0] exp);
        begin
            checks = checks + 1;
            if (got !== exp) begin
                n_errors = n_errors + 1;
                $display("[FAIL] %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    // m sine ticks, 4 cycles high and 4 low
    task tk(input integer m);
        repeat (m) begin
            @(posedge clk); #1 tick = 1'b1;
            repeat (4) @(posedge clk);
            #1 tick = 1'b0;
            repeat (4) @(posedge clk);
        end
    endtask
    task give_verdict;
        begin
            if (n_errors == 0 && checks > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    // system clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // watchdog
    initial begin
        #600000;
        n_errors = n_errors + 1;
        give_verdict;
    end
    // main sequence
    initial begin
        rst = 1'b1; tick = 1'b0; avalid = 1'b0; fblank = 8'h0; flive = 4'h0; adata = 10'h0;
        n_errors = 0; checks = 0;
        k = $urandom(9732);
        repeat (6) @(posedge clk);
        chk({oe, miso, chan, done}, 4'h0);
        #1 rst = 1'b0;
        repeat (4) @(posedge clk);
        for (k = 0; k < 2; k = k + 1) begin
            host.cpol = k[0];
            host.xfer(32, {8'h01, 24'h0}, r);
            chk(r[31:0], {8'h01, IDV, {8{IDV[0]}}});
        end
        host.xfer(24, 24'h2b0000, r);
        chk(r[15:0], 16'h003f);
        v = $urandom;
        host.xfer(32, {8'h3b, v, 8'h0}, r);
        chk(r[31:0], 32'h3b000000);
        host.xfer(24, 24'h2b0000, r);
        chk(r[15:0], v);
        host.xfer(24, 24'h3b0002, r);
        k = $urandom % 8;
        @(posedge clk); #1 fblank = 8'h1 << k;
        repeat (20) @(posedge clk);
        host.xfer(24, 24'h020000, r);
        chk(r[15:0], 16'h0);
        tk(1);
        host.xfer(24, 24'h020000, r);
        chk(r[15:0], 16'h0);
        tk(2);
        @(posedge clk); #1 fblank = 8'h0;
        tk(4);
        host.xfer(24, 24'h020000, r);
        chk(r[15:0], sbit(k));
        host.xfer(24, 24'h020000, r);
        chk(r[15:0], 16'h0);
        for (nsel = 0; nsel < 4; nsel = nsel + 1) begin
            host.xfer(24, {8'h3a, 10'h0, nsel[1:0], 4'h1}, r);
            repeat (SETTLE + 12) @(posedge clk);
            si = 16'h0; sq = 16'h0;
            for (j = 0; j < 2 * (4 << (nsel > 1 ? 2 : nsel)); j = j + 1) begin
                @(posedge clk); #1;
                adata = $urandom;
                avalid = 1'b1;
                chk(chan, j[0]);
                if (j[0]) sq = sq + adata; else si = si + adata;
                @(posedge clk); #1 avalid = 1'b0;
                repeat (2) @(posedge clk);
            end
            repeat (3) @(posedge clk);
            chk(done, 1'b1);
            host.xfer(24, 24'h050000, r);
            chk(r[0], 1'b1);
            // a second start while done is set must be ignored
            host.xfer(24, {8'h3a, 10'h0, nsel[1:0], 4'h1}, r);
            repeat (SETTLE + 12) @(posedge clk);
            #1 avalid = 1'b1;
            @(posedge clk); #1 avalid = 1'b0;
            @(posedge clk); #1;
            chk({chan, done}, 2'h1);
            if (nsel[0]) begin
                host.xfer(48, {8'h90, 40'h0}, r);
                chk(r, {8'h90, si, sq, {8{sq[0]}}});
                host.xfer(24, 24'h030000, r);
                chk(r[15:0], 16'h0);
            end else begin
                host.xfer(24, 24'h040000, r);
                chk(r[15:0], sq);
                host.xfer(24, 24'h3a0000, r);
            end
            chk(done, 1'b0);
            if (nsel[0])
                host.xfer(24, 24'h3a0000, r);
        end
        // continuous mode: two 4-pair sets back to back, results swap in whole
        host.xfer(24, 24'h3a0002, r);
        repeat (SETTLE + 12) @(posedge clk);
        si = 16'h0;
        sq = 16'h0;
        for (j = 0; j < 16; j = j + 1) begin
            @(posedge clk); #1;
            adata = $urandom;
            avalid = 1'b1;
            chk(chan, j[0]);
            if (j[0]) sq = sq + adata; else si = si + adata;
            @(posedge clk); #1 avalid = 1'b0;
            repeat (2) @(posedge clk);
            if (j == 7) begin
                host.xfer(48, {8'h90, 40'h0}, r);
                chk(r, {8'h90, si, sq, {8{sq[0]}}});
                chk(done, 1'b0);
                si = 16'h0;
                sq = 16'h0;
            end
        end
        repeat (3) @(posedge clk);
        host.xfer(24, 24'h030000, r);
        chk(r[15:0], si);
        host.xfer(24, 24'h040000, r);
        chk(r[15:0], sq);
        host.xfer(24, 24'h3a0000, r);
        give_verdict;
    end
endmodule
